// File: logic/sbw_pkg.sv
// constants, field layouts and encodings for the setup, watchdog and diagnosis registers
package sbw_pkg;
	// frame: 16 bits, least significant first; [2:0] mode, [5:3] select, [15:6] data
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] FRAME_CNT = 5'h10;
	localparam logic [4:0] HDR_CNT = 5'h06;
	localparam logic [4:0] CNT_MAX = 5'h1F;
	localparam logic [2:0] MODE_READ_ONLY = 3'h7;
	localparam logic [2:0] SEL_THRESHOLD = 3'h4;
	localparam logic [2:0] SEL_COMM = 3'h5;
	localparam logic [2:0] SEL_WD = 3'h6;
	localparam logic [2:0] SEL_DIAG = 3'h7;
	localparam int MODE_LSB = 0;
	localparam int SEL_LSB = 3;
	localparam int DATA_LSB = 6;
	localparam int DATA_W = 10;
	// comm_setup stored as {lin[1:0], can[1:0], slope}
	localparam logic [4:0] COMM_RST = 5'h01;
	localparam int COMM_SLOPE_POS = 0;
	localparam int COMM_CAN_LSB = 1;
	localparam int COMM_LIN_LSB = 3;
	// watchdog_setup stored as {parity, type, enable, reserved, period[4:0]}
	localparam logic [8:0] WD_RST = 9'h1EF;
	localparam int WD_RSV_POS = 5;
	localparam int WD_EN_POS = 6;
	localparam int WD_TYPE_POS = 7;
	localparam int PAR_HI = 13;
	localparam int PAR_LO = 6;
	localparam int PAR_POS = 14;
	// sampled pin vector layout
	localparam int PIN_W = 6;
	localparam int PIN_SCLK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_HW = 3;
	localparam logic [5:0] PIN_RST = 6'h02;
	localparam int HW_SDEV = 2;
	typedef enum logic [1:0] {
		SBW_CELL_OFF = 2'h0,
		SBW_CELL_WAKE = 2'h1,
		SBW_CELL_RX_ONLY = 2'h2,
		SBW_CELL_NORMAL = 2'h3
	} sbw_cell_e;
	typedef enum logic [1:0] {
		SBW_THR_INVALID = 2'h0,
		SBW_THR_LEVEL_ONE = 2'h1,
		SBW_THR_LEVEL_TWO = 2'h2,
		SBW_THR_LEVEL_THREE = 2'h3
	} sbw_thr_e;
	typedef enum logic [1:0] {
		SBW_RC_NONE = 2'h0,
		SBW_RC_SUPPLY_UV = 2'h1,
		SBW_RC_WD_FIRST = 2'h2,
		SBW_RC_SPI_OR_EXT = 2'h3
	} sbw_rc_e;
	typedef enum logic [2:0] {
		SBW_FB_NONE = 3'h0,
		SBW_FB_UV_TIMEOUT = 3'h1,
		SBW_FB_WD_ONE = 3'h2,
		SBW_FB_WD_TWO = 3'h3,
		SBW_FB_INIT_TIMEOUT = 3'h4,
		SBW_FB_OVERTEMP = 3'h5,
		SBW_FB_RESET_CLAMP = 3'h6,
		SBW_FB_RESERVED = 3'h7
	} sbw_fb_e;
	// watchdog period arithmetic in ms, 11 bits wide
	localparam logic [4:0] PER_SPLIT = 5'h10;
	localparam logic [10:0] PER_ONE = 11'h001;
	localparam logic [10:0] PER_STEP_LO = 11'h010;
	localparam logic [10:0] PER_STEP_HI = 11'h030;
	localparam logic [10:0] PER_OFFSET = 11'h1D0;
endpackage

// File: logic/sbw_period.sv
// watchdog period code to period in milliseconds, registered
`timescale 1ns/10ps
module sbw_period import sbw_pkg::*; (
	input wire logic clk, // core clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [4:0] code, // period code
	output logic [10:0] ms_q // period in ms
);
	typedef struct packed {
		logic [10:0] ms;
	} sbw_per_s;
	sbw_per_s s_q;
	sbw_per_s s_d;
	logic [10:0] c11;

	always_comb begin
		c11 = {6'h00, code};
		s_d = s_q;
		if (code < PER_SPLIT) begin
			s_d.ms = 11'((c11 + PER_ONE) * PER_STEP_LO);
		end else begin
			s_d.ms = 11'(c11 * PER_STEP_HI - PER_OFFSET);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q.ms <= 11'(({6'h00, WD_RST[4:0]} + PER_ONE) * PER_STEP_LO);
		end else begin
			s_q <= s_d;
		end
	end

	assign ms_q = s_q.ms;

	low_range_a: assert property (@(posedge clk) disable iff (rst)
		(code < PER_SPLIT) |=> (ms_q == 11'(({6'h00, $past(code)} + 11'h001) * 11'h010)))
		else $error("low watchdog period wrong");
	high_range_a: assert property (@(posedge clk) disable iff (rst)
		(code >= PER_SPLIT) |=> (ms_q == 11'({6'h00, $past(code)} * 11'h030 - 11'h1D0)))
		else $error("high watchdog period wrong");
endmodule

// File: logic/sbw_regs.sv
// serial setup, watchdog and diagnosis registers of the system basis chip
`timescale 1ns/10ps
module sbw_regs import sbw_pkg::*; (
	input wire logic clk, // core clock, 200 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic spi_sclk, // serial clock pin
	input wire logic spi_cs_n, // chip select pin, active low
	input wire logic spi_sdi, // serial data in pin
	output logic spi_sdo, // serial data out
	output logic spi_sdo_oe, // data out enable
	input wire logic [2:0] hwcfg_pins, // hardware configuration pins
	input wire logic wd_fail, // watchdog failure pulse
	input wire logic wd_serviced, // watchdog correctly served pulse
	input wire logic wd_fail_count_select, // 0 one failure, 1 two failures
	input wire logic restart_cause_set, // restart event pulse
	input wire logic [1:0] restart_cause_in, // restart event code
	input wire logic fallback_set, // fallback event pulse
	input wire logic [2:0] fallback_cause_in, // fallback event code
	input wire logic lh_off, // fallback output switched off pulse
	input wire logic mode_exit, // leaving sleep or fail-safe pulse
	output logic lin_low_slope_bit, // LIN cells in low slope
	output logic [1:0] can_cell_mode, // CAN cell mode
	output logic [1:0] lin_cell_mode_field, // LIN cell mode
	output logic wd_type_select, // 1 time-out, 0 window
	output logic wd_enable_bit, // watchdog active
	output logic [10:0] wd_period_ms, // watchdog period in ms
	output logic wd_restart, // watchdog timing restart pulse
	output logic [1:0] threshold_level, // reset threshold level
	output logic sw_dev_mode, // software development mode
	output logic restart_req, // restart request pulse
	output logic lh_activate // fallback output activation pulse
);
	typedef enum logic [1:0] {
		SBW_ST_IDLE = 2'b01,
		SBW_ST_SHIFT = 2'b10
	} sbw_st_e;
	typedef struct packed {
		sbw_st_e st;
		logic [PIN_W-1:0] sy1;
		logic [PIN_W-1:0] sy2;
		logic [PIN_W-1:0] sy3;
		logic [PIN_W-1:0] filt;
		logic [FRAME_BITS-1:0] rx;
		logic [FRAME_BITS-1:0] tx;
		logic [FRAME_BITS-1:0] resp;
		logic [4:0] cnt;
		logic [4:0] comm;
		logic [8:0] wd;
		logic [1:0] thr;
		logic [1:0] rc;
		logic [2:0] fb;
		logic fail_one;
		logic wd_restart;
		logic restart_req;
		logic lh_activate;
	} sbw_regs_s;
	sbw_regs_s s_q;
	sbw_regs_s s_d;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic frame_end;
	logic [2:0] f_mode;
	logic [2:0] f_sel;
	logic [DATA_W-1:0] f_data;
	logic wr_ok;
	logic wd_par_ok;
	logic ro_diag;
	logic [4:0] wd_code;

	// read data of one select code, in the data field of the frame
	function automatic logic [DATA_W-1:0] reg_data(input logic [2:0] sel, input sbw_regs_s s);
		logic [DATA_W-1:0] r;
		r = '0;
		case (sel)
			SEL_THRESHOLD: r = {8'h00, s.thr};
			SEL_COMM: r = {5'h00, s.comm};
			SEL_WD: r = {1'b0, s.wd};
			SEL_DIAG: r = {2'h0, s.filt[PIN_HW +: 3], s.fb, s.rc};
			default: r = '0;
		endcase
		return r;
	endfunction

	always_comb begin
		frame_end = 1'b0;
		f_mode = s_q.rx[MODE_LSB +: 3];
		f_sel = s_q.rx[SEL_LSB +: 3];
		f_data = s_q.rx[DATA_LSB +: DATA_W];
		wr_ok = f_mode != MODE_READ_ONLY;
		wd_par_ok = (^s_q.rx[PAR_HI:PAR_LO]) == s_q.rx[PAR_POS];
		ro_diag = 1'b0;
		wd_code = s_q.wd[4:0];
		s_d = s_q;
		s_d.wd_restart = 1'b0;
		s_d.restart_req = 1'b0;
		s_d.lh_activate = 1'b0;
		// three-stage sampling; a change counts when stages two and three agree
		s_d.sy1 = {hwcfg_pins, spi_sdi, spi_cs_n, spi_sclk};
		s_d.sy2 = s_q.sy1;
		s_d.sy3 = s_q.sy2;
		s_d.filt = (~(s_q.sy2 ^ s_q.sy3) & s_q.sy2) | ((s_q.sy2 ^ s_q.sy3) & s_q.filt);
		sclk_rise = s_d.filt[PIN_SCLK] & ~s_q.filt[PIN_SCLK];
		sclk_fall = ~s_d.filt[PIN_SCLK] & s_q.filt[PIN_SCLK];
		cs_fall = ~s_d.filt[PIN_CS] & s_q.filt[PIN_CS];
		case (s_q.st)
			SBW_ST_IDLE: begin
				if (cs_fall) begin
					s_d.st = SBW_ST_SHIFT;
					s_d.cnt = '0;
					s_d.tx = s_q.resp; // answer prepared by the previous frame
				end
			end
			SBW_ST_SHIFT: begin
				if (s_d.filt[PIN_CS]) begin
					s_d.st = SBW_ST_IDLE;
					frame_end = s_q.cnt == FRAME_CNT;
				end else if (sclk_rise) begin
					s_d.rx = {s_q.filt[PIN_SDI], s_q.rx[FRAME_BITS-1:1]};
					if (s_q.cnt != CNT_MAX) begin
						s_d.cnt = 5'(s_q.cnt + 5'h01);
					end
					// read-only answers in this frame once the header is in
					if (5'(s_q.cnt + 5'h01) == HDR_CNT
						&& s_d.rx[FRAME_BITS-HDR_CNT +: 3] == MODE_READ_ONLY) begin
						s_d.tx[DATA_W:1] = reg_data(s_d.rx[FRAME_BITS-3 +: 3], s_q);
					end
				end else if (sclk_fall) begin
					s_d.tx = {1'b0, s_q.tx[FRAME_BITS-1:1]};
				end
			end
			default: begin
				s_d.st = SBW_ST_IDLE;
			end
		endcase
		if (frame_end) begin
			s_d.resp = {reg_data(f_sel, s_q), f_sel, f_mode};
			if (wr_ok) begin
				case (f_sel)
					SEL_COMM: s_d.comm = f_data[4:0];
					SEL_WD: begin
						if (wd_par_ok) begin
							s_d.wd = f_data[8:0];
							s_d.wd[WD_RSV_POS] = 1'b1;
							s_d.wd_restart = 1'b1;
							s_d.fail_one = 1'b0;
						end
					end
					SEL_THRESHOLD: begin
						if (f_data[1:0] != SBW_THR_INVALID) begin
							s_d.thr = f_data[1:0];
						end
					end
					default: s_d.thr = s_d.thr; // diagnosis select stores nothing
				endcase
			end else begin
				ro_diag = f_sel == SEL_DIAG;
			end
		end
		if (wd_serviced) begin
			s_d.fail_one = 1'b0;
		end
		// clears first, so an event in the same cycle wins
		if (ro_diag || mode_exit) begin
			s_d.rc = SBW_RC_NONE;
		end
		if (lh_off) begin
			s_d.fb = SBW_FB_NONE;
		end
		if (restart_cause_set) begin
			s_d.rc = restart_cause_in;
		end
		if (fallback_set && fallback_cause_in != SBW_FB_RESERVED) begin
			s_d.fb = fallback_cause_in;
		end
		if (wd_fail && !s_q.filt[PIN_HW + HW_SDEV]) begin
			if (!wd_fail_count_select || s_q.fail_one) begin
				s_d.lh_activate = 1'b1;
				s_d.fail_one = 1'b0;
				s_d.fb = wd_fail_count_select ? SBW_FB_WD_TWO : SBW_FB_WD_ONE;
			end else begin
				s_d.fail_one = 1'b1;
				s_d.restart_req = 1'b1;
				s_d.rc = SBW_RC_WD_FIRST;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.st <= SBW_ST_IDLE;
			s_q.sy1 <= PIN_RST;
			s_q.sy2 <= PIN_RST;
			s_q.sy3 <= PIN_RST;
			s_q.filt <= PIN_RST;
			s_q.comm <= COMM_RST;
			s_q.wd <= WD_RST;
			s_q.thr <= SBW_THR_LEVEL_ONE;
		end else begin
			s_q <= s_d;
		end
	end

	sbw_period u_period (
		.clk(clk),
		.rst(rst),
		.code(wd_code),
		.ms_q(wd_period_ms)
	);

	assign spi_sdo = s_q.tx[0];
	assign spi_sdo_oe = s_q.st == SBW_ST_SHIFT;
	assign lin_low_slope_bit = s_q.comm[COMM_SLOPE_POS];
	assign can_cell_mode = s_q.comm[COMM_CAN_LSB +: 2];
	assign lin_cell_mode_field = s_q.comm[COMM_LIN_LSB +: 2];
	assign wd_enable_bit = s_q.wd[WD_EN_POS];
	assign wd_type_select = s_q.wd[WD_TYPE_POS];
	assign wd_restart = s_q.wd_restart;
	assign threshold_level = s_q.thr;
	assign sw_dev_mode = s_q.filt[PIN_HW + HW_SDEV];
	assign restart_req = s_q.restart_req;
	assign lh_activate = s_q.lh_activate;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence wd_write_s;
		frame_end && wr_ok && f_sel == SEL_WD && wd_par_ok;
	endsequence
	sequence restart_pulse_s;
		wd_restart ##1 !wd_restart;
	endsequence

	comm_write_a: assert property (frame_end && wr_ok && f_sel == SEL_COMM
		|=> {lin_cell_mode_field, can_cell_mode, lin_low_slope_bit} == $past(f_data[4:0]))
		else $error("comm setup write not applied");
	wd_accept_a: assert property (wd_write_s |=> restart_pulse_s
		and wd_type_select == $past(s_q.rx[DATA_LSB + WD_TYPE_POS])
		and wd_enable_bit == $past(s_q.rx[DATA_LSB + WD_EN_POS]))
		else $error("watchdog write not applied");
	parity_drop_a: assert property (frame_end && f_sel == SEL_WD && !wd_par_ok
		|=> $stable(s_q.wd) && !wd_restart)
		else $error("bad parity write changed watchdog");
	rsv_fixed_a: assert property (s_q.wd[WD_RSV_POS])
		else $error("reserved watchdog bit not one");
	thr_valid_a: assert property (threshold_level != SBW_THR_INVALID)
		else $error("invalid threshold stored");
	rc_clear_a: assert property ((ro_diag || mode_exit) && !restart_cause_set && !wd_fail
		|=> s_q.rc == SBW_RC_NONE)
		else $error("restart cause not cleared");
	fb_clear_a: assert property (lh_off && !fallback_set && !wd_fail
		|=> s_q.fb == SBW_FB_NONE ##1 1'b1)
		else $error("fallback cause not cleared");
	fb_no_res_a: assert property (s_q.fb != SBW_FB_RESERVED)
		else $error("reserved fallback cause shown");
	sdev_quiet_a: assert property (wd_fail && sw_dev_mode
		|=> !restart_req && !lh_activate)
		else $error("development mode acted on failure");
	single_fail_a: assert property (wd_fail && !sw_dev_mode && !wd_fail_count_select
		|=> lh_activate && s_q.fb == SBW_FB_WD_ONE)
		else $error("single failure did not activate fallback");
	diag_ro_a: assert property (frame_end && f_sel == SEL_DIAG
		|=> $stable(s_q.comm) && $stable(s_q.wd) && $stable(s_q.thr))
		else $error("diagnosis write changed a setting");
endmodule

// File: dv/sbw_host.sv
// serial master model standing in for the microcontroller
`timescale 1ns/10ps
module sbw_host (
	input wire logic clk, // bench clock
	output logic sclk, // serial clock, idle low
	output logic cs_n, // chip select, idle high
	output logic sdi, // serial data to the device
	input wire logic sdo, // serial data from the device
	input wire logic sdo_oe // device drives sdo
);
	localparam int HALF = 16; // 80 ns half period of the link clock

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// lsb first; fewer than 16 clocks makes a frame the device must drop
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge clk);
		cs_n <= 1'b0;
		wt(HALF);
		for (int i = 0; i < nbits; i++) begin
			sdi <= tx[i];
			wt(HALF);
			rx[i] = (sdo_oe === 1'b1) ? sdo : 1'bx;
			sclk <= 1'b1;
			wt(HALF);
			sclk <= 1'b0;
		end
		wt(HALF);
		cs_n <= 1'b1;
		sdi <= 1'b0; // released line falls to its pull-down
		wt(8);
	endtask
endmodule

// File: dv/sbw_regs_test.sv
// self-checking bench for the setup, watchdog and diagnosis registers
`timescale 1ns/10ps
module sbw_regs_test import sbw_pkg::*;;
	logic clk, rst, sclk, cs_n, sdi, sdo, sdo_oe, wd_sel, slope, wd_t, wd_e, wd_rs, sdev, rq, lh;
	logic [2:0] hw, fb_in;
	logic [1:0] rc_in, can_m, lin_m, thr;
	logic [10:0] per_ms;
	logic [5:0] evs;
	int n_errors = 0, n_checks = 0, cyc = 0, n_rs = 0, n_rq = 0, n_lh = 0;
	int e_comm = 1, e_thr = 1, e_per = 256, e_te = 3;
	int wd_codes[4] = '{0, 15, 16, 31};
	int thr_codes[5] = '{2, 3, 0, 1, 0};

	sbw_host host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

	sbw_regs dut_u (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
		.spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .hwcfg_pins(hw), .wd_fail(evs[0]),
		.wd_serviced(evs[5]), .wd_fail_count_select(wd_sel), .restart_cause_set(evs[1]),
		.restart_cause_in(rc_in), .fallback_set(evs[2]), .fallback_cause_in(fb_in),
		.lh_off(evs[3]), .mode_exit(evs[4]), .lin_low_slope_bit(slope), .can_cell_mode(can_m),
		.lin_cell_mode_field(lin_m), .wd_type_select(wd_t), .wd_enable_bit(wd_e),
		.wd_period_ms(per_ms), .wd_restart(wd_rs), .threshold_level(thr), .sw_dev_mode(sdev),
		.restart_req(rq), .lh_activate(lh));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		n_rs <= n_rs + int'(wd_rs === 1'b1);
		n_rq <= n_rq + int'(rq === 1'b1);
		n_lh <= n_lh + int'(lh === 1'b1);
		if (cyc == 40000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (n_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic int per(input int n);
		return (n < 16) ? (n + 1) * 16 : n * 48 - 464;
	endfunction

	task automatic wr(input logic [2:0] sel, input logic [9:0] d);
		logic [15:0] rx;
		host_u.xfer({d, sel, 3'h5}, 16, rx);
		repeat (6) @(posedge clk);
	endtask

	task automatic rd_diag(input logic [7:0] e);
		logic [15:0] rx;
		host_u.xfer({10'h000, SEL_DIAG, MODE_READ_ONLY}, 16, rx);
		chk(rx[13:6], e);
		repeat (6) @(posedge clk);
	endtask

	// one-cycle pulse: 0 failure, 1 restart set, 2 fallback set, 3 output off, 4 mode exit,
	// 5 watchdog served
	task automatic evt(input int which);
		@(posedge clk);
		evs <= 6'h01 << which;
		@(posedge clk);
		evs <= 6'h00;
		repeat (8) @(posedge clk);
	endtask

	initial begin
		int r, n, d, c;
		logic [9:0] wd;
		logic [15:0] rx;
		rst = 1'b1;
		hw = 3'h0;
		wd_sel = 1'b1;
		rc_in = 2'h0;
		fb_in = 3'h0;
		evs = 6'h00;
		r = $urandom(21);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		chk({lin_m, can_m, slope}, e_comm);
		chk({wd_t, wd_e, per_ms}, {e_te[1:0], 11'h100});
		chk({thr, sdo_oe}, {e_thr[1:0], 1'b0});
		for (int k = 0; k < 4; k++) begin
			d = (k << 3) | (k << 1) | int'($urandom % 2);
			c = e_comm;
			wr(SEL_COMM, d[9:0]);
			e_comm = d;
			chk({lin_m, can_m, slope}, e_comm);
		end
		host_u.xfer({10'h000, SEL_COMM, 3'h5}, 15, rx);
		repeat (6) @(posedge clk);
		chk({lin_m, can_m, slope}, e_comm);
		chk(rx[10:0], {c[4:0], SEL_COMM, 3'h5});
		host_u.xfer({10'h3FF, SEL_COMM, MODE_READ_ONLY}, 16, rx);
		repeat (6) @(posedge clk);
		chk({rx[10:6], lin_m, can_m, slope}, {e_comm[4:0], e_comm[4:0]});
		foreach (thr_codes[k]) begin
			if (thr_codes[k] != 0) e_thr = thr_codes[k];
			wr(SEL_THRESHOLD, 10'(thr_codes[k]));
			chk(thr, e_thr);
		end
		for (int i = 0; i < 8; i++) begin
			n = (i < 4) ? wd_codes[i] : int'($urandom % 32);
			wd = {2'b00, i[0], i[1], 1'b1, n[4:0]};
			wd[8] = ^wd[7:0] ^ (i == 5 || i == 7);
			c = n_rs;
			wr(SEL_WD, wd);
			if (i != 5 && i != 7) begin
				e_per = per(n);
				e_te = i[0] * 2 + i[1];
			end
			chk(per_ms, e_per);
			chk({wd_t, wd_e}, e_te);
			chk(n_rs - c, int'(i != 5 && i != 7));
		end
		hw <= 3'h3;
		rc_in <= 2'h1;
		fb_in <= 3'h5;
		evt(1);
		evt(2);
		rd_diag({3'h3, 3'h5, 2'h1});
		rc_in <= 2'h3;
		fb_in <= 3'h7;
		evt(1);
		evt(2);
		rd_diag({3'h3, 3'h5, 2'h3});
		rd_diag({3'h3, 3'h5, 2'h0});
		wr(SEL_DIAG, 10'h3FF);
		chk({lin_m, can_m, slope, thr}, {e_comm[4:0], e_thr[1:0]});
		rc_in <= 2'h2;
		evt(1);
		evt(4);
		evt(3);
		rd_diag({3'h3, 3'h0, 2'h0});
		hw <= 3'h0;
		repeat (8) @(posedge clk);
		c = n_rq;
		n = n_lh;
		evt(0);
		chk({n_rq - c, n_lh - n}, {32'd1, 32'd0});
		evt(0);
		chk(n_lh - n, 1);
		wd_sel <= 1'b0;
		evt(0);
		chk({n_rq - c, n_lh - n}, {32'd1, 32'd2});
		rd_diag({3'h0, 3'h2, 2'h2});
		hw <= 3'h4;
		repeat (8) @(posedge clk);
		chk(sdev, 1);
		evt(0);
		evt(0);
		chk({n_rq - c, n_lh - n}, {32'd1, 32'd2});
		hw <= 3'h0;
		wd_sel <= 1'b1;
		repeat (8) @(posedge clk);
		evt(0);
		evt(5);
		evt(0);
		chk({n_rq - c, n_lh - n}, {32'd3, 32'd2});
		stop_test();
	end
endmodule
